// ==== design/hspd_deglitch.sv ====
`timescale 1ns/100ps
module hspd_deglitch #(
	parameter int LIMIT = 400000
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic active,
	output logic fired
);

	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
	localparam logic [CW-1:0] DONE = CW'(LIMIT);
	localparam logic [CW-1:0] ZERO = '0;

	logic [CW-1:0] count;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// The count saturates so one uninterrupted assertion gives one pulse.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (!active) begin
			count <= ZERO; // R23
		end else if (count != DONE) begin
			count <= count + CW'(1); // R11
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fired <= 1'b0;
		end else begin
			fired <= active && (count == LAST); // R11
		end
	end

	dropout_clears_a: assert property (@(posedge ref_clk) disable iff (rst)
		!active |=> count == ZERO) else $error("deglitch count not cleared on dropout"); // R23
	fire_after_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
		fired |-> $past(active) && $past(count) == LAST) else $error("deglitch fired early"); // R11

endmodule

// ==== design/hspd_fault_logic.sv ====
`timescale 1ns/100ps
// What this block and its host do
// R01: Channel command is parallel pin OR serially loaded control bit.
// R02: Parallel pin reaches the gate driver without serial clock or chip-select.
// R03: Pin low-then-high during retry wait restarts timer and re-enables that channel.
// R04: Toggling a parallel pin never clears the latched fault interrupt.
// R05: Over-voltage, open load, over-current or short latch interrupt low at once.
// R06: Latched interrupt releases only on a chip-select falling edge.
// R07: Over-voltage forces all four gates off and latches the interrupt.
// R08: Over-voltage sets no channel bit; release needs it gone and no bits.
// R09: After over-voltage ends, gates follow their commands again immediately.
// R10: Open-load monitoring runs only while both pin and serial bit are zero.
// R11: Open load accepted only after comparator stays high the whole deglitch time.
// R12: Valid open load latches the interrupt and sets that channel's fault bits.
// R13: Fault status is eight bits, two per channel, coding the fault kind.
// R14: Latched mode: open-load channel stays off until commanded on, off, on.
// R15: Retry mode: open load starts retry timer; gate follows after the delay.
// R16: One retry timer serves all channels; first fault sets the delay.
// R17: On-state fault switches that gate off and reports interrupt and bits.
// R18: Host keeps chip-select high when serial port and interrupt are unused.
// R19: Host reading faults only shifts all-zero control bits.
// R20: Host never commands on an unused channel with source tied to gate.
// R21: While chip-select is high, faults since its last rising edge are captured.
// R22: Chip-select rising edge loads four control bits and clears fault register.
// R23: Deglitch count returns to zero whenever the comparator drops early.
module hspd_fault_logic #(
	parameter int OL_DEGLITCH_CYCLES = hspd_pkg::OPEN_LOAD_DEGLITCH_CYCLES,
	parameter int RETRY_CYCLES = hspd_pkg::AUTO_RETRY_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] parallel_channel_cmd,
	input wire logic cs_n,
	input wire logic [3:0] serial_ctrl_in,
	input wire logic auto_retry_select,
	input wire logic supply_overvoltage_lockout,
	input wire hspd_pkg::hspd_sense_t fet_source_sense,
	output logic [3:0] fet_drive_out,
	output logic [3:0] serial_ctrl,
	output logic [7:0] fault_status,
	output logic fault_interrupt_n
);

	localparam int RW = $clog2(RETRY_CYCLES + 1);
	localparam logic [RW-1:0] RETRY_LAST = RW'(RETRY_CYCLES - 1);

	logic cs_prev;
	logic cs_fall;
	logic cs_rise;
	logic [3:0] par_prev;
	logic [3:0] par_rise;
	logic [3:0] cmd;
	logic [3:0] on_fault;
	logic [3:0] ol_fault;
	logic [3:0] ch_fault;
	logic [3:0] lock;
	logic [3:0] seen_on;
	logic [3:0] retry_pend;
	logic [3:0] next_drive;
	logic retry_done;
	logic retry_restart;
	logic retry_start;
	logic [RW-1:0] retry_count;
	hspd_pkg::hspd_retry_state_t retry_state;

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cs_prev <= 1'b1;
			par_prev <= hspd_pkg::CH_ALL_OFF;
		end else begin
			cs_prev <= cs_n;
			par_prev <= parallel_channel_cmd;
		end
	end

	assign cs_fall = cs_prev && !cs_n;
	assign cs_rise = !cs_prev && cs_n;
	assign par_rise = parallel_channel_cmd & ~par_prev;

	// ------------------------------------------------------------
	// Serial control bits
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			serial_ctrl <= hspd_pkg::CH_ALL_OFF;
		end else if (cs_rise) begin
			serial_ctrl <= serial_ctrl_in; // R22
		end
	end

	assign cmd = parallel_channel_cmd | serial_ctrl; // R01 R02

	// ------------------------------------------------------------
	// Shared auto-retry timer
	// ------------------------------------------------------------
	// A later fault does not restart a running wait, so the first one sets the delay.
	assign retry_start = auto_retry_select && (|ch_fault) && (retry_state == hspd_pkg::HSPD_RT_IDLE); // R16
	assign retry_restart = |(par_rise & retry_pend); // R03
	assign retry_done = (retry_state == hspd_pkg::HSPD_RT_RUN) && (retry_count == RETRY_LAST) && !retry_restart;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			retry_state <= hspd_pkg::HSPD_RT_IDLE;
			retry_count <= '0;
		end else begin
			unique case (retry_state)
				hspd_pkg::HSPD_RT_IDLE: begin
					retry_count <= '0;
					if (retry_start) begin
						retry_state <= hspd_pkg::HSPD_RT_RUN; // R15
					end
				end
				hspd_pkg::HSPD_RT_RUN: begin
					if (retry_restart) begin
						retry_count <= '0; // R03
					end else if (retry_done) begin
						retry_state <= hspd_pkg::HSPD_RT_IDLE;
						retry_count <= '0;
					end else begin
						retry_count <= retry_count + RW'(1);
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Per-channel supervision
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < hspd_pkg::NUM_CH; i++) begin : g_ch
			logic [1:0] code;

			// Sensing only while the channel is commanded off keeps the pull-up from faking a fault.
			hspd_deglitch #(
				.LIMIT(OL_DEGLITCH_CYCLES)
			) u_ol (
				.ref_clk(ref_clk),
				.rst(rst),
				.active(fet_source_sense.open_load_cmp[i] && !cmd[i]), // R10
				.fired(ol_fault[i])
			);

			// An on-state fault only counts while this gate is actually driven.
			assign on_fault[i] = fet_drive_out[i] &&
				(fet_source_sense.over_current[i] || fet_source_sense.short_to_ground[i]); // R17
			assign ch_fault[i] = on_fault[i] || ol_fault[i];

			always_comb begin
				if (fet_drive_out[i] && fet_source_sense.short_to_ground[i]) begin
					code = hspd_pkg::FCODE_SHORT_GND;
				end else if (on_fault[i]) begin
					code = hspd_pkg::FCODE_OVER_CURRENT;
				end else if (ol_fault[i]) begin
					code = hspd_pkg::FCODE_OPEN_LOAD;
				end else begin
					code = hspd_pkg::FCODE_NONE;
				end
			end

			// The first fault since the last read is kept; a new one wins over the clear.
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					fault_status[2*i +: 2] <= hspd_pkg::FCODE_NONE;
				end else if (ch_fault[i] && (fault_status[2*i +: 2] == hspd_pkg::FCODE_NONE || cs_rise)) begin
					fault_status[2*i +: 2] <= code; // R12 R13 R21
				end else if (cs_rise) begin
					fault_status[2*i +: 2] <= hspd_pkg::FCODE_NONE; // R22
				end
			end

			// Latched mode: the channel is released by an on, then an off command.
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					lock[i] <= 1'b0;
					seen_on[i] <= 1'b0;
				end else if (!auto_retry_select && ch_fault[i]) begin
					lock[i] <= 1'b1; // R14 R17
					seen_on[i] <= on_fault[i];
				end else if (lock[i]) begin
					if (cmd[i]) begin
						seen_on[i] <= 1'b1;
					end else if (seen_on[i] && !fet_source_sense.open_load_cmp[i]) begin
						lock[i] <= 1'b0; // R14
						seen_on[i] <= 1'b0;
					end
				end
			end

			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					retry_pend[i] <= 1'b0;
				end else if (auto_retry_select && ch_fault[i]) begin
					retry_pend[i] <= 1'b1; // R15
				end else if (par_rise[i] || retry_done) begin
					retry_pend[i] <= 1'b0; // R03 R15
				end
			end

			assign next_drive[i] = cmd[i] && !supply_overvoltage_lockout && !lock[i] &&
				!retry_pend[i] && !ch_fault[i]; // R07 R09

			sequence pin_retoggle;
				!parallel_channel_cmd[i] ##1 parallel_channel_cmd[i];
			endsequence

			follow_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
				!supply_overvoltage_lockout && !lock[i] && !retry_pend[i] && !ch_fault[i]
				|=> fet_drive_out[i] == $past(cmd[i])) else $error("gate does not follow command"); // R01 R09
			ol_only_off_a: assert property (@(posedge ref_clk) disable iff (rst)
				ol_fault[i] |-> $past(!cmd[i], 1)) else $error("open load sensed while commanded on"); // R10
			retoggle_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
				retry_pend[i] ##0 pin_retoggle and (!ch_fault[i] [*2])
				|=> !retry_pend[i]) else $error("pin retoggle did not re-enable"); // R03
			onfault_off_a: assert property (@(posedge ref_clk) disable iff (rst)
				on_fault[i] |=> !fet_drive_out[i] ##0 fault_status[2*i +: 2] != hspd_pkg::FCODE_NONE)
				else $error("on-state fault not handled"); // R17
			latch_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
				lock[i] && !cmd[i] && !seen_on[i] && !ch_fault[i] |=> lock[i]) else $error("lock left early"); // R14
		end
	endgenerate

	// ------------------------------------------------------------
	// Gate outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fet_drive_out <= hspd_pkg::CH_ALL_OFF;
		end else begin
			fet_drive_out <= next_drive; // R02
		end
	end

	// ------------------------------------------------------------
	// Fault interrupt
	// ------------------------------------------------------------
	// Over-voltage is held as a level, so the release waits for it to clear.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fault_interrupt_n <= 1'b1;
		end else if (supply_overvoltage_lockout || (|ch_fault)) begin
			fault_interrupt_n <= 1'b0; // R05 R07 R12
		end else if (cs_fall && fault_status == hspd_pkg::FAULT_BITS_CLEAR) begin
			fault_interrupt_n <= 1'b1; // R04 R06 R08
		end
	end

	ov_gates_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		supply_overvoltage_lockout |=> fet_drive_out == hspd_pkg::CH_ALL_OFF) else $error("gate on in over-voltage"); // R07
	fault_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
		supply_overvoltage_lockout || (|ch_fault) |=> !fault_interrupt_n) else $error("interrupt not latched"); // R05
	release_on_cs_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(fault_interrupt_n) |-> $past(cs_fall) && !$past(supply_overvoltage_lockout))
		else $error("interrupt released without cs fall"); // R04 R06 R08
	ov_no_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
		supply_overvoltage_lockout && ch_fault == hspd_pkg::CH_ALL_OFF && fault_status == hspd_pkg::FAULT_BITS_CLEAR
		&& !cs_rise |=> fault_status == hspd_pkg::FAULT_BITS_CLEAR) else $error("over-voltage set a fault bit"); // R08
	ctrl_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		cs_rise |=> serial_ctrl == $past(serial_ctrl_in)) else $error("control bits not loaded"); // R22
	retry_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
		retry_count <= RETRY_LAST) else $error("retry count overran"); // R15 R16

	// ------------------------------------------------------------
	// Shared timer, fault register and interrupt checks
	// ------------------------------------------------------------
	// The timer and the pending bits show at no port, so they are watched here.
	// A wrong restart would only appear as a late gate edge many cycles on.
	// Keeping one timer saves area, but a second fault waits on the first one's count.

	sequence retry_arm;
		retry_state == hspd_pkg::HSPD_RT_IDLE && retry_start;
	endsequence

	sequence retry_running;
		retry_state == hspd_pkg::HSPD_RT_RUN && !retry_restart && !retry_done;
	endsequence

	timer_start_a: assert property (@(posedge ref_clk) disable iff (rst) // R15
		retry_arm |=> retry_state == hspd_pkg::HSPD_RT_RUN && retry_count == '0)
		else $error("retry timer did not start");

	timer_steady_a: assert property (@(posedge ref_clk) disable iff (rst) // R16
		retry_running |=> retry_state == hspd_pkg::HSPD_RT_RUN && retry_count == $past(retry_count) + RW'(1))
		else $error("retry timer restarted by a later fault");

	restart_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // R03
		retry_state == hspd_pkg::HSPD_RT_RUN && retry_restart |=> retry_count == '0)
		else $error("retry timer not reset by pin retoggle");

	pend_release_a: assert property (@(posedge ref_clk) disable iff (rst) // R15
		retry_done && ch_fault == hspd_pkg::CH_ALL_OFF |=> retry_pend == hspd_pkg::CH_ALL_OFF)
		else $error("retry expiry left a channel pending");

	bits_cleared_a: assert property (@(posedge ref_clk) disable iff (rst) // R22
		cs_rise && ch_fault == hspd_pkg::CH_ALL_OFF |=> fault_status == hspd_pkg::FAULT_BITS_CLEAR)
		else $error("fault bits not cleared on cs rise");

	toggle_keeps_a: assert property (@(posedge ref_clk) disable iff (rst) // R04
		!fault_interrupt_n && !cs_fall |=> !fault_interrupt_n)
		else $error("interrupt released without cs fall");

endmodule

// ==== design/hspd_pkg.sv ====
package hspd_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int NS_PER_MS = 1000000;
	localparam int OPEN_LOAD_DEGLITCH_TIME_MS = 16;
	localparam int AUTO_RETRY_TIME_MS = 120;
	// A least time rounds up to whole cycles.
	localparam int OPEN_LOAD_DEGLITCH_CYCLES =
		(OPEN_LOAD_DEGLITCH_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AUTO_RETRY_CYCLES = (AUTO_RETRY_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Channels and fault codes
	// ------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int CODE_W = 2;
	localparam logic [1:0] FCODE_NONE = 2'h0;
	localparam logic [1:0] FCODE_OPEN_LOAD = 2'h1;
	localparam logic [1:0] FCODE_OVER_CURRENT = 2'h2;
	localparam logic [1:0] FCODE_SHORT_GND = 2'h3;
	localparam logic [3:0] CH_ALL_OFF = 4'h0;
	localparam logic [7:0] FAULT_BITS_CLEAR = 8'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] over_current;
		logic [3:0] short_to_ground;
		logic [3:0] open_load_cmp;
	} hspd_sense_t;

	typedef enum logic [0:0] {
		HSPD_RT_IDLE = 1'b0,
		HSPD_RT_RUN = 1'b1
	} hspd_retry_state_t;

endpackage

// ==== dv/hspd_fet_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// External switch and load
// ------------------------------------------------------------
// No channel here has its source tied to its gate, so the bench may command any of them.
module hspd_fet_model (
	input wire logic [3:0] fet_drive_out,
	input wire logic [3:0] open_load,
	input wire logic [3:0] over_current,
	input wire logic [3:0] shorted,
	output hspd_pkg::hspd_sense_t fet_source_sense
);
	// The pull-up lifts the source only while the gate is low, so an open load shows only then.
	assign fet_source_sense.open_load_cmp = open_load & ~fet_drive_out;
	// On-state faults need current through a conducting switch.
	assign fet_source_sense.over_current = over_current & fet_drive_out;
	assign fet_source_sense.short_to_ground = shorted & fet_drive_out;
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] pcmd = 4'h0;
	logic cs_n = 1'b1;
	logic [3:0] ser = 4'h0;
	logic ar = 1'b0;
	logic ov = 1'b0;
	logic [3:0] ol = 4'h0;
	logic [3:0] oc = 4'h0;
	logic [3:0] sh = 4'h0;
	hspd_pkg::hspd_sense_t sense;
	logic [3:0] drv;
	logic [3:0] sctl;
	logic [7:0] fstat;
	logic fint_n;
	int mismatches = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'h26;
	logic [31:0] r;
	logic ov_v;

	always #20 ref_clk = ~ref_clk;

	hspd_fault_logic #(.OL_DEGLITCH_CYCLES(8), .RETRY_CYCLES(20)) hspd_fault_logic_i (.ref_clk(ref_clk),
		.rst(rst), .parallel_channel_cmd(pcmd), .cs_n(cs_n), .serial_ctrl_in(ser), .auto_retry_select(ar),
		.supply_overvoltage_lockout(ov), .fet_source_sense(sense), .fet_drive_out(drv), .serial_ctrl(sctl),
		.fault_status(fstat), .fault_interrupt_n(fint_n));
	hspd_fet_model hspd_fet_model_i (.fet_drive_out(drv), .open_load(ol), .over_current(oc), .shorted(sh),
		.fet_source_sense(sense));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [3:0] exp_gate(input logic [3:0] cmd, input logic lock);
		return cmd & {4{~lock}};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic cs_cycle(input logic [3:0] v);
		cs_n <= 1'b0;
		tick(2);
		ser <= v;
		cs_n <= 1'b1;
		tick(2);
	endtask

	task automatic ol_fault(input logic [3:0] ch, input int n);
		ol <= ch;
		tick(n);
		ol <= 4'h0;
		tick(2);
	endtask

	task automatic tally_and_finish();
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#400000;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		tick(20);
		rst <= 1'b0;
		tick(2);
		for (int i = 0; i < 40; i++) begin
			r = xs();
			ov_v = (r[6:4] == 3'h0);
			pcmd <= r[3:0];
			ov <= ov_v;
			tick(1);
			`CHK(drv, exp_gate(r[3:0], ov_v))
			if (ov_v) `CHK(fint_n, 1'b0)
			`CHK(fstat, 8'h00)
		end
		pcmd <= 4'hf;
		ov <= 1'b1;
		tick(1);
		`CHK(drv, 4'h0)
		`CHK(fint_n, 1'b0)
		ov <= 1'b0;
		tick(1);
		`CHK(drv, 4'hf)
		pcmd <= 4'h0;
		tick(1);
		pcmd <= 4'hf;
		tick(1);
		`CHK(fint_n, 1'b0)
		pcmd <= 4'h0;
		cs_n <= 1'b0;
		tick(2);
		`CHK(fint_n, 1'b1)
		cs_n <= 1'b1;
		tick(1);
		for (int i = 0; i < 4; i++) begin
			r = xs();
			cs_cycle(r[3:0]);
			`CHK(sctl, r[3:0])
			pcmd <= r[7:4];
			tick(1);
			`CHK(drv, r[3:0] | r[7:4])
		end
		cs_cycle(4'h0);
		pcmd <= 4'h0;
		tick(1);
		ol_fault(4'h4, 7);
		`CHK(fstat, 8'h00)
		`CHK(fint_n, 1'b1)
		ol_fault(4'h4, 12);
		`CHK(fstat, 8'h10)
		`CHK(fint_n, 1'b0)
		cs_n <= 1'b0;
		tick(2);
		`CHK(fint_n, 1'b0)
		cs_n <= 1'b1;
		tick(2);
		`CHK(fstat, 8'h00)
		pcmd <= 4'h4;
		tick(2);
		`CHK(drv, 4'h0)
		pcmd <= 4'h0;
		tick(2);
		pcmd <= 4'h4;
		tick(2);
		`CHK(drv, 4'h4)
		ov <= 1'b1;
		pcmd <= 4'h1;
		ol <= 4'h1;
		tick(12);
		ol <= 4'h0;
		tick(1);
		ov <= 1'b0;
		tick(1);
		`CHK(fstat, 8'h00)
		pcmd <= 4'h0;
		cs_n <= 1'b0;
		tick(2);
		`CHK(fint_n, 1'b1)
		cs_n <= 1'b1;
		ar <= 1'b1;
		tick(1);
		ol_fault(4'h1, 12);
		cs_cycle(4'h1);
		`CHK(drv, 4'h0)
		tick(25);
		`CHK(drv, 4'h1)
		cs_cycle(4'h0);
		ol_fault(4'h2, 12);
		pcmd <= 4'h2;
		tick(2);
		`CHK(drv, 4'h2)
		pcmd <= 4'h0;
		ar <= 1'b0;
		cs_cycle(4'h0);
		for (int i = 0; i < 2; i++) begin
			pcmd <= 4'h8;
			tick(2);
			oc <= (i == 0) ? 4'h8 : 4'h0;
			sh <= (i == 1) ? 4'h8 : 4'h0;
			tick(3);
			`CHK(drv, 4'h0)
			`CHK(fstat[7:6], (i == 0) ? 2'h2 : 2'h3)
			`CHK(fint_n, 1'b0)
			pcmd <= 4'h0;
			oc <= 4'h0;
			sh <= 4'h0;
			cs_cycle(4'h0);
		end
		tally_and_finish();
	end
endmodule
